//--- core/mtvm_attr_decode.sv
// Attribute byte decoder for display enable, reverse, underline and blink.
`timescale 1ns/1ps
module mtvm_attr_decode (
	// Attribute side
	mtvm_attr_if.decoder a
);
	import mtvm_pkg::*;

	logic [5:0] colour;

	assign colour = {a.attr[6:4], a.attr[2:0]};

	assign a.visible   = |colour;
	assign a.reverse   = (colour == 6'b111_000);
	assign a.underline = (colour == 6'b000_001);
	assign a.blink     = (a.attr[ATTR_BLINK_BIT] && a.blink_en && !a.cursor_on) ? a.blink_wave : 1'b1;
endmodule

//--- core/mtvm_top.sv
// Monochrome text video mixer with shared video memory and host wait control.
// ****************************************
// ****************************************
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module mtvm_top (
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address, data and response
	input  wire logic [31:0]                 s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [31:0]                 s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Timing from the clock generator and display controller
	input  wire logic                        dot_oscillator,
	input  wire logic                        controller_char_clock,
	input  wire logic                        access_phase_clock,
	input  wire logic                        shift_load_n,
	input  wire logic                        host_write_phase,
	input  wire logic                        vsync,
	input  wire logic                        crtc_cursor,
	input  wire logic [mtvm_pkg::VRAM_AW-1:0] crtc_addr,
	input  wire logic [mtvm_pkg::ROW_W-1:0]   row_addr,
	// Character generator
	output logic [mtvm_pkg::GEN_AW-1:0]      chargen_addr,
	input  wire logic [7:0]                  chargen_data,
	// Host memory bus
	input  wire logic                        host_mem_read_n,
	input  wire logic                        host_mem_write_n,
	input  wire logic [mtvm_pkg::HOST_AW-1:0] host_addr,
	input  wire logic [7:0]                  host_wdata,
	output logic [7:0]                       host_rdata,
	output logic                             host_rdata_oe,
	output logic                             host_ready,
	output logic                             host_ready_oe,
	// Video
	output logic                             video_out
);
	import mtvm_pkg::*;

	// ****************************************
	// Storage and state
	// ****************************************
	logic [7:0]         char_mem [VRAM_DEPTH];
	logic [7:0]         attr_mem [VRAM_DEPTH];
	logic [31:0]        ctrl;
	logic               dot_prev;
	logic               cc_prev;
	logic               ap_prev;
	logic               sl_prev;
	logic               vs_prev;
	logic [VDIV_W-1:0]  vdiv;
	logic               window;
	logic [7:0]         attr_latch;
	logic [7:0]         shifter;
	mtvm_host_state_t   hstate;
	logic               mem_we;
	logic [7:0]         host_mem_q;
	logic               cursor_blink;
	logic               pixel;
	logic               dot_rise;
	logic               cc_rise;
	logic               ap_rise;
	logic               sl_fall;
	logic               strobes_idle;
	logic               aw_held;
	logic               w_held;
	logic [31:0]        aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;

	mtvm_attr_if attr_bus ();

	mtvm_attr_decode u_decode (
		.a (attr_bus)
	);

	assign dot_rise     = dot_oscillator && !dot_prev;
	assign cc_rise      = controller_char_clock && !cc_prev;
	assign ap_rise      = access_phase_clock && !ap_prev;
	assign sl_fall      = !shift_load_n && sl_prev;
	assign strobes_idle = host_mem_read_n && host_mem_write_n;
	assign host_mem_q   = host_addr[0] ? attr_mem[host_addr[HOST_AW-1:1]] : char_mem[host_addr[HOST_AW-1:1]];

	// ****************************************
	// Edge detection of the timing inputs
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dot_prev <= 1'b0;
			cc_prev  <= 1'b0;
			ap_prev  <= 1'b0;
			sl_prev  <= 1'b1;
			vs_prev  <= 1'b0;
		end else begin
			dot_prev <= dot_oscillator;
			cc_prev  <= controller_char_clock;
			ap_prev  <= access_phase_clock;
			sl_prev  <= shift_load_n;
			vs_prev  <= vsync;
		end
	end

	// Vertical sync divider feeding cursor and character blink.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vdiv <= '0;
		end else if (vsync && !vs_prev) begin
			vdiv <= vdiv + 1'b1;
		end
	end

	assign cursor_blink = crtc_cursor && vdiv[VDIV_CURSOR_BIT];

	assign attr_bus.attr       = attr_latch;
	assign attr_bus.blink_en   = ctrl[CTRL_BLINK_EN_BIT];
	assign attr_bus.cursor_on  = crtc_cursor;
	assign attr_bus.blink_wave = vdiv[VDIV_BLINK_BIT];

	// ****************************************
	// Host access window
	// ****************************************
	// set on fall, clear on rise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			window <= 1'b0;
		end else if (sl_fall) begin
			window <= 1'b1;
		end else if (cc_rise) begin
			window <= 1'b0;
		end
	end

	// ****************************************
	// Host access sequencer
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hstate        <= HS_IDLE;
			host_ready    <= 1'b1;
			host_ready_oe <= 1'b0;
			host_rdata_oe <= 1'b0;
			host_rdata    <= 8'h00;
		end else begin
			unique case (hstate)
				HS_IDLE: begin
					if (!host_mem_read_n) begin
						hstate        <= HS_RD_WAIT;
						host_ready    <= 1'b0;
						host_ready_oe <= 1'b1;
					end else if (!host_mem_write_n) begin
						hstate        <= HS_WR_WAIT;
						host_ready    <= 1'b0;
						host_ready_oe <= 1'b1;
					end
				end
				HS_RD_WAIT: begin
					if (window && access_phase_clock) begin
						host_rdata    <= host_mem_q;
						host_rdata_oe <= 1'b1;
						host_ready    <= 1'b1;
						hstate        <= HS_DONE;
					end
				end
				HS_WR_WAIT: begin
					if (mem_we) begin
						hstate <= HS_WR_DONE;
					end
				end
				HS_WR_DONE: begin
					if (cc_rise) begin
						host_ready <= 1'b1;
						hstate     <= HS_DONE;
					end
				end
				HS_DONE: begin
					if (strobes_idle) begin
						host_ready_oe <= 1'b0;
						host_rdata_oe <= 1'b0;
						hstate        <= HS_IDLE;
					end
				end
			endcase
		end
	end

	assign mem_we = (hstate == HS_WR_WAIT) && window && host_write_phase && !host_mem_write_n;

	// ****************************************
	// Video memory
	// ****************************************
	// The host may only write while the access phase clock gives it the slot.
	always_ff @(posedge aclk) begin
		if (mem_we && access_phase_clock) begin
			if (host_addr[0]) begin
				attr_mem[host_addr[HOST_AW-1:1]] <= host_wdata;
			end else begin
				char_mem[host_addr[HOST_AW-1:1]] <= host_wdata;
			end
		end
	end

	// ****************************************
	// Controller fetch
	// ****************************************
	// controller slot fetch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chargen_addr <= '0;
			attr_latch   <= 8'h00;
		end else if (ap_rise) begin
			chargen_addr <= {char_mem[crtc_addr], row_addr};
			attr_latch   <= attr_mem[crtc_addr];
		end
	end

	// load while low, shift per dot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shifter <= 8'h00;
		end else if (!shift_load_n) begin
			shifter <= chargen_data;
		end else if (dot_rise) begin
			shifter <= {shifter[6:0], 1'b0};
		end
	end

	// ****************************************
	// Pixel mixer
	// ****************************************
	// dot OR underline
	assign pixel = ((((shifter[7] || attr_bus.underline) && attr_bus.visible && attr_bus.blink)
		|| cursor_blink) ^ attr_bus.reverse);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			video_out <= 1'b0;
		end else if (dot_rise) begin
			video_out <= pixel && ctrl[CTRL_VIDEO_EN_BIT];
		end
	end

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	// Address and data are held independently so either may arrive first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 32'h0000_0000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			ctrl          <= CTRL_RESET;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr[7:2] == CTRL_OFFSET[7:2] && aw_addr[31:8] == 24'h00_0000) begin
					s_axi_bresp <= RESP_OKAY;
					for (int i = 0; i < 4; i++) begin
						if (w_strb[i]) begin
							ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
						end
					end
				end else if (aw_addr[7:2] == STATUS_OFFSET[7:2] && aw_addr[31:8] == 24'h00_0000) begin
					s_axi_bresp <= RESP_OKAY;
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= 32'h0000_0000;
				s_axi_rresp  <= RESP_OKAY;
				if (s_axi_araddr[31:8] != 24'h00_0000) begin
					s_axi_rresp <= RESP_SLVERR;
				end else if (s_axi_araddr[7:2] == CTRL_OFFSET[7:2]) begin
					s_axi_rdata <= ctrl;
				end else if (s_axi_araddr[7:2] == STATUS_OFFSET[7:2]) begin
					s_axi_rdata[ST_WINDOW_BIT] <= window;
					s_axi_rdata[ST_READY_BIT]  <= host_ready;
					s_axi_rdata[ST_CURSOR_BIT] <= cursor_blink;
					s_axi_rdata[ST_BLINK_BIT]  <= attr_bus.blink;
					s_axi_rdata[ST_VIDEO_BIT]  <= video_out;
				end else begin
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

//--- shared/mtvm_attr_if.sv
// Attribute decode signals passed between the mixer and its decoder.
`timescale 1ns/1ps
interface mtvm_attr_if;
	logic [7:0] attr;
	logic       blink_en;
	logic       cursor_on;
	logic       blink_wave;
	logic       visible;
	logic       reverse;
	logic       underline;
	logic       blink;

	modport mixer (output attr, output blink_en, output cursor_on, output blink_wave,
		input visible, input reverse, input underline, input blink);
	modport decoder (input attr, input blink_en, input cursor_on, input blink_wave,
		output visible, output reverse, output underline, output blink);
endinterface

//--- shared/mtvm_pkg.sv
// Constants and types shared by the text video mixer files.
package mtvm_pkg;

	// ****************************************
	// Video memory geometry
	// ****************************************
	localparam int unsigned VRAM_AW     = 11;
	localparam int unsigned VRAM_DEPTH  = 2048;
	localparam int unsigned HOST_AW     = 12;
	localparam int unsigned ROW_W       = 4;
	localparam int unsigned GEN_AW      = 12;

	// ****************************************
	// Attribute byte fields
	// ****************************************
	localparam int unsigned ATTR_BLINK_BIT = 7;

	// ****************************************
	// Vertical sync divider: bit 3 gives /16, bit 4 gives /32
	// ****************************************
	localparam int unsigned VDIV_W          = 5;
	localparam int unsigned VDIV_CURSOR_BIT = 3;
	localparam int unsigned VDIV_BLINK_BIT  = 4;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam int unsigned CTRL_VIDEO_EN_BIT = 3;
	localparam int unsigned CTRL_BLINK_EN_BIT = 6;
	localparam int unsigned ST_WINDOW_BIT     = 0;
	localparam int unsigned ST_READY_BIT      = 1;
	localparam int unsigned ST_CURSOR_BIT     = 2;
	localparam int unsigned ST_BLINK_BIT      = 3;
	localparam int unsigned ST_VIDEO_BIT      = 4;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ****************************************
	// Host access sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		HS_IDLE    = 5'b00001,
		HS_RD_WAIT = 5'b00010,
		HS_WR_WAIT = 5'b00100,
		HS_WR_DONE = 5'b01000,
		HS_DONE    = 5'b10000
	} mtvm_host_state_t;

endpackage

//--- sim/mtvm_checker.sv
// Port-level assertions for the text video mixer.
`timescale 1ns/1ps
module mtvm_checker
	import mtvm_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// AXI4-Lite
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	// Timing and video
	input wire logic        dot_oscillator,
	input wire logic        access_phase_clock,
	input wire logic [3:0]  row_addr,
	input wire logic [11:0] chargen_addr,
	input wire logic        video_out,
	// Host bus
	input wire logic        host_mem_read_n,
	input wire logic        host_mem_write_n,
	input wire logic        host_ready,
	input wire logic        host_ready_oe,
	input wire logic        host_rdata_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ****
	// Host wait control
	// ****
	a_read_drops_ready: assert property (!host_ready_oe && !host_mem_read_n |=> host_ready_oe && !host_ready)
		else $error("read strobe did not drop ready");
	a_write_drops_ready: assert property (!host_ready_oe && host_mem_read_n && !host_mem_write_n
		|=> host_ready_oe && !host_ready) else $error("write strobe did not drop ready");
	a_ready_holds: assert property (host_ready_oe && host_ready && !(host_mem_read_n && host_mem_write_n)
		|=> host_ready_oe && host_ready) else $error("ready left before release");
	a_ready_floats: assert property (host_ready_oe && host_ready && host_mem_read_n && host_mem_write_n
		|=> !host_ready_oe && !host_rdata_oe) else $error("ready not floated");
	a_rdata_with_ready: assert property ($rose(host_ready) && !host_mem_read_n |-> host_rdata_oe)
		else $error("read data not driven with ready");
	a_wait_bounded: assert property ($fell(host_ready) |-> ##[1:64] host_ready)
		else $error("host wait too long");
	// ****
	// Video path and register bus
	// ****
	a_gen_row: assert property ($rose(access_phase_clock) |-> ##[1:2] chargen_addr[3:0] == row_addr)
		else $error("generator row wrong");
	a_video_on_dot: assert property (!$rose(dot_oscillator) |=> $stable(video_out))
		else $error("video moved without dot rise");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held after handshake");
	a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read data not zero");
	c_host_read: cover property ($rose(host_ready) && !host_mem_read_n);
	c_host_write: cover property ($rose(host_ready) && !host_mem_write_n);
	c_video_lit: cover property ($rose(video_out));
endmodule
bind mtvm_top mtvm_checker chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .dot_oscillator, .access_phase_clock, .row_addr, .chargen_addr,
	.video_out, .host_mem_read_n, .host_mem_write_n, .host_ready, .host_ready_oe, .host_rdata_oe);

//--- sim/mtvm_timing_model.sv
// Timing source and character generator standing in for the display side.
`timescale 1ns/1ps
module mtvm_timing_model (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Generator address
	input  wire logic [11:0] chargen_addr,
	// Timing and generator data
	output logic             dot_oscillator,
	output logic             controller_char_clock,
	output logic             access_phase_clock,
	output logic             shift_load_n,
	output logic             host_write_phase,
	output logic [7:0]       chargen_data,
	output logic [3:0]       phase
);
	// ****
	// Character period of sixteen cycles
	// ****
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= 4'h0;
		end else begin
			phase <= phase + 4'h1;
		end
	end
	// Load falls just before the host half ends, so the window meets the phase.
	assign access_phase_clock = phase[3];
	assign controller_char_clock = phase[2];
	assign dot_oscillator = phase[0];
	assign shift_load_n = (phase != 4'hd);
	assign host_write_phase = (phase[3:1] == 3'h7);
	// Odd codes light every dot, so attributes alone decide the pixel.
	assign chargen_data = {8{chargen_addr[4]}};
endmodule

//--- sim/mtvm_top_tb.sv
// Self-checking bench for the text video mixer.
`timescale 1ns/1ps
module mtvm_top_tb;
	import mtvm_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, vsync = 1'h0, crtc_cursor = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, row_addr = 4'h9, phase;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic dot_oscillator, controller_char_clock, access_phase_clock, shift_load_n, host_write_phase;
	logic [10:0] crtc_addr = 11'h0;
	logic [11:0] chargen_addr, host_addr = 12'h0;
	logic [7:0] chargen_data, host_wdata = 8'h0, host_rdata, q;
	logic host_mem_read_n = 1'h1, host_mem_write_n = 1'h1, host_rdata_oe, host_ready, host_ready_oe, video_out;
	int n_fail = 0, compares = 0;

	mtvm_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dot_oscillator,
		.controller_char_clock, .access_phase_clock, .shift_load_n, .host_write_phase, .vsync, .crtc_cursor,
		.crtc_addr, .row_addr, .chargen_addr, .chargen_data, .host_mem_read_n, .host_mem_write_n, .host_addr,
		.host_wdata, .host_rdata, .host_rdata_oe, .host_ready, .host_ready_oe, .video_out);
	mtvm_timing_model far_u (.aclk, .aresetn, .chargen_addr, .dot_oscillator, .controller_char_clock,
		.access_phase_clock, .shift_load_n, .host_write_phase, .chargen_data, .phase);

	always #2 aclk = ~aclk;

	// ****
	// Shared tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task complete_run;
		$display("counts: fail %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo(input logic ok);
		if (!ok) begin
			chk("wait_done", 32'h1, 32'h0);
			complete_run();
		end
	endtask
	task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) begin
				done = 1'h1;
				chk("bresp", er, s_axi_bresp);
			end
		end
		s_axi_bready <= 1'h0;
		tmo(done);
	endtask
	task automatic axr(input logic [31:0] a, input logic [1:0] er, input logic [31:0] ed);
		logic done;
		done = 1'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) begin
				done = 1'h1;
				chk("rresp", er, s_axi_rresp);
				chk("rdata", ed, s_axi_rdata);
			end
		end
		s_axi_rready <= 1'h0;
		tmo(done);
	endtask
	// The host holds its strobe through every wait state until ready returns.
	task automatic hacc(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int i;
		host_addr <= a;
		host_wdata <= d;
		host_mem_write_n <= !wr;
		host_mem_read_n <= wr;
		repeat (2) @(posedge aclk);
		chk("ready_wait", 32'h2, {host_ready_oe, host_ready});
		for (i = 0; i < 80 && host_ready !== 1'h1; i++) @(posedge aclk);
		tmo(host_ready === 1'h1);
		q = host_rdata;
		chk("rdata_oe", !wr, host_rdata_oe);
		host_mem_read_n <= 1'h1;
		host_mem_write_n <= 1'h1;
		repeat (2) @(posedge aclk);
		chk("float", 32'h0, {host_ready_oe, host_rdata_oe});
	endtask
	task automatic vchk(input logic [7:0] ch, input logic [7:0] at, input logic cur, input logic e);
		int i;
		hacc(1'h1, 12'h000, ch);
		hacc(1'h1, 12'h001, at);
		crtc_cursor <= cur;
		repeat (40) @(posedge aclk);
		for (i = 0; i < 20 && phase != 4'h6; i++) @(posedge aclk);
		tmo(phase == 4'h6);
		chk("video", e, video_out);
	endtask
	task automatic vpulse(input int n);
		repeat (n) begin
			vsync <= 1'h1;
			repeat (2) @(posedge aclk);
			vsync <= 1'h0;
			repeat (2) @(posedge aclk);
		end
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (16) @(posedge aclk);
		chk("reset_outs", 32'h8, {host_ready, host_ready_oe, host_rdata_oe, video_out});
		chk("reset_gen", 32'h0, chargen_addr);
		aresetn <= 1'h1;
		@(posedge aclk);
		axr(CTRL_OFFSET, RESP_OKAY, CTRL_RESET);
		axw(CTRL_OFFSET, 32'h8, RESP_OKAY);
		axr(CTRL_OFFSET, RESP_OKAY, 32'h8);
		axw(32'h10, 32'h1, RESP_SLVERR);
		axr(32'h10, RESP_SLVERR, 32'h0);
		axw(STATUS_OFFSET, 32'h0, RESP_OKAY);
		hacc(1'h1, 12'h006, 8'h5a);
		hacc(1'h0, 12'h006, 8'h00);
		chk("readback", 32'h5a, q);
		vchk(8'h01, 8'h07, 1'h0, 1'h1);
		vchk(8'h02, 8'h07, 1'h0, 1'h0);
		vchk(8'h02, 8'h01, 1'h0, 1'h1);
		vchk(8'h01, 8'h00, 1'h0, 1'h0);
		vchk(8'h01, 8'h70, 1'h0, 1'h0);
		vchk(8'h02, 8'h70, 1'h0, 1'h1);
		vchk(8'h01, 8'h87, 1'h0, 1'h1);
		vchk(8'h01, 8'h00, 1'h1, 1'h0);
		vpulse(8);
		vchk(8'h01, 8'h00, 1'h1, 1'h1);
		// Called on the phase 6 edge, so the window is closed when the status word is taken.
		axr(STATUS_OFFSET, RESP_OKAY, 32'h0000_001e);
		axw(CTRL_OFFSET, 32'h48, RESP_OKAY);
		vchk(8'h01, 8'h87, 1'h0, 1'h0);
		vpulse(8);
		vchk(8'h01, 8'h87, 1'h0, 1'h1);
		axw(CTRL_OFFSET, 32'h0, RESP_OKAY);
		vchk(8'h01, 8'h07, 1'h0, 1'h0);
		complete_run();
	end
endmodule
